// File: rtl/tpsf_core.sv
// translation unit: low-power channels, security lookup, hit under miss, terminate faults
// assumes one 100 MHz clock; the walk engine and downstream sit outside on plain handshakes
`timescale 1ns/100ps
module tpsf_core #(
   parameter int CTX_W      = 4,
   parameter int NUM_CTX    = 4,
   parameter int SEC_IDX_W  = 4,
   parameter int TLB_N      = 4,
   parameter int WBUF_DEPTH = 4,
   parameter logic [(1<<SEC_IDX_W)-1:0] FIXED_SEC_MASK = '0,
   parameter logic [(1<<SEC_IDX_W)-1:0] PROG_MASK      = '1,
   parameter logic [(1<<SEC_IDX_W)-1:0] PROG_SEC_INIT  = '0
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 arst_n_i,
   // register port
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [3:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output      logic [31:0]          wb_dat_o,
   output      logic                 wb_ack_o,
   input  wire logic                 reg_clk_en_i,
   // low-power channels
   input  wire logic                 lp_req_cache_i,
   output      logic                 lp_ack_cache_o,
   output      logic                 lp_active_cache_o,
   input  wire logic                 lp_req_walk_i,
   output      logic                 lp_ack_walk_o,
   output      logic                 lp_active_walk_o,
   // incoming transactions
   input  wire logic                 req_valid_i,
   input  wire tpsf_pkg::tpsf_txn_type req_i,
   output      logic                 req_ready_o,
   // downstream
   output      logic                 fwd_valid_o,
   output      tpsf_pkg::tpsf_fwd_type fwd_o,
   input  wire logic                 fwd_ready_i,
   input  wire logic                 fwd_done_i,
   // terminate responses
   output      logic                 abort_valid_o,
   output      tpsf_pkg::tpsf_fwd_type abort_o,
   input  wire logic                 abort_ready_i,
   // table walk and snoop
   output      logic                 walk_req_o,
   output      logic [31:0]          walk_addr_o,
   input  wire logic                 walk_done_i,
   input  wire logic                 walk_fault_i,
   input  wire logic [tpsf_pkg::VP_W-1:0] walk_ppage_i,
   input  wire logic                 snoop_valid_i
);

   localparam int IW  = (SEC_IDX_W == 0) ? 1 : SEC_IDX_W;
   localparam int TBL = 1 << IW;
   localparam int TW  = (TLB_N > 1) ? $clog2(TLB_N) : 1;
   // context ids are cut to the built width everywhere, so lookups and fills agree
   localparam logic [tpsf_pkg::ID_W-1:0] CTX_MASK = tpsf_pkg::ID_W'((1 << CTX_W) - 1);

   // ****************************************
   // configuration checks
   // ****************************************
   initial begin
      a_cfg_unique : assert ((FIXED_SEC_MASK & PROG_MASK) == '0)
         else $error("security index listed twice");
      a_cfg_has_ns : assert ((~FIXED_SEC_MASK) != '0)
         else $error("no non-secure security entry");
      a_cfg_prog_n : assert ($countones(PROG_MASK) >= 1 && $countones(PROG_MASK) <= 32)
         else $error("programmable entry count out of range");
      a_cfg_widths : assert (CTX_W >= 1 && CTX_W <= 15 && SEC_IDX_W <= 15)
         else $error("sideband width out of range");
   end

   // ****************************************
   // register port
   // ****************************************
   logic [2:0]            ctrl;
   logic                  fault_st;
   logic [31:0]           fault_addr;
   logic [TBL-1:0]        prog_sec;
   logic [TBL-1:0]        eff_sec;
   logic [IW-1:0]         sec_sel;
   logic [TW:0]           maint_cnt;
   logic                  maint_busy;
   logic                  wb_take;
   logic                  wb_wr;
   logic                  fault_evt;
   tpsf_pkg::tpsf_miss_type miss_st;

   // requests are taken only on enabled edges so a slow port sees one ack
   assign wb_take    = wb_cyc_i & wb_stb_i & reg_clk_en_i & ~wb_ack_o;
   assign wb_wr      = wb_take & wb_we_i & (wb_sel_i == 4'hF);
   assign maint_busy = (maint_cnt != '0);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_take;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wb_dat_o <= 32'h0;
      end else if (wb_take) begin
         case (wb_adr_i)
            tpsf_pkg::REG_CTRL:   wb_dat_o <= {29'h0, ctrl};
            tpsf_pkg::REG_STATUS: wb_dat_o <= {28'h0, abort_valid_o, maint_busy,
                                               (miss_st != tpsf_pkg::M_IDLE), fault_st};
            tpsf_pkg::REG_SECTAB: wb_dat_o <= {eff_sec[sec_sel], 31'(sec_sel)};
            tpsf_pkg::REG_FADDR:  wb_dat_o <= fault_addr;
            default:              wb_dat_o <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl <= tpsf_pkg::CTRL_RST;
      end else if (wb_wr && wb_adr_i == tpsf_pkg::REG_CTRL) begin
         ctrl <= wb_dat_i[2:0];
      end
   end

   // a maintenance run walks every cache entry; input is held off meanwhile
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         maint_cnt <= '0;
      end else if (maint_busy) begin
         maint_cnt <= maint_cnt - 1'b1;
      end else if (wb_wr && wb_adr_i == tpsf_pkg::REG_CTRL && wb_dat_i[tpsf_pkg::CTRL_MAINT]) begin
         maint_cnt <= (TW+1)'(TLB_N);
      end
   end

   // sticky fault: a new fault in the clearing cycle survives
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fault_st <= 1'b0;
      end else if (fault_evt) begin
         fault_st <= 1'b1;
      end else if (wb_wr && wb_adr_i == tpsf_pkg::REG_STATUS && wb_dat_i[tpsf_pkg::ST_FAULT]) begin
         fault_st <= 1'b0;
      end
   end

   // only programmable entries take writes; fixed ones never move
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prog_sec <= TBL'(PROG_SEC_INIT);
         sec_sel  <= '0;
      end else if (wb_wr && wb_adr_i == tpsf_pkg::REG_SECTAB) begin
         sec_sel <= wb_dat_i[IW-1:0];
         if (PROG_MASK[wb_dat_i[IW-1:0]]) begin
            prog_sec[wb_dat_i[IW-1:0]] <= wb_dat_i[tpsf_pkg::SEC_BIT];
         end
      end
   end

   // ****************************************
   // security table and cache lookup
   // ****************************************
   logic [TLB_N-1:0]          tlb_v;
   logic [tpsf_pkg::ID_W-1:0] tlb_ctx [TLB_N];
   logic [tpsf_pkg::VP_W-1:0] tlb_vp  [TLB_N];
   logic [tpsf_pkg::VP_W-1:0] tlb_pp  [TLB_N];
   logic [TLB_N-1:0]          hit_vec;
   logic [tpsf_pkg::ID_W-1:0] ctx;
   logic [tpsf_pkg::VP_W-1:0] vpage;

   // context id from the channel's own sideband, cut to the built width
   assign ctx   = (req_i.write ? req_i.ctx_wr : req_i.ctx_rd) & CTX_MASK;
   assign vpage = req_i.addr[tpsf_pkg::ADDR_W-1:tpsf_pkg::PAGE_LSB];

   genvar g;
   generate
      for (g = 0; g < TBL; g++) begin : g_sec
         if (g < (1 << SEC_IDX_W)) begin : g_used
            // fixed secure, else programmable, else fixed non-secure
            assign eff_sec[g] = FIXED_SEC_MASK[g] | (PROG_MASK[g] & prog_sec[g]);
         end else begin : g_none
            assign eff_sec[g] = 1'b0;
         end
      end
      for (g = 0; g < TLB_N; g++) begin : g_tlb
         assign hit_vec[g] = tlb_v[g] && tlb_ctx[g] == ctx && tlb_vp[g] == vpage;
      end
   endgenerate

   logic                      hit;
   logic [tpsf_pkg::VP_W-1:0] hit_pp;
   logic                      ns_sel;
   logic [IW-1:0]             sidx;

   assign hit  = |hit_vec;
   assign sidx = (SEC_IDX_W == 0) ? '0 : req_i.sec_idx[IW-1:0];

   always_comb begin
      hit_pp = '0;
      for (int i = 0; i < TLB_N; i++) begin
         hit_pp = hit_pp | (hit_vec[i] ? tlb_pp[i] : '0);
      end
      if (ctrl[tpsf_pkg::CTRL_MODE]) begin
         ns_sel = ~eff_sec[sidx];
      end else begin
         ns_sel = req_i.write ? req_i.ns_wr : req_i.ns_rd;
      end
   end

   // ****************************************
   // transaction flow
   // ****************************************
   tpsf_pkg::tpsf_txn_type    miss_txn;
   logic [tpsf_pkg::ID_W-1:0] miss_ctx;
   logic                      miss_ns;
   logic                      miss_fault;
   logic [tpsf_pkg::VP_W-1:0] miss_pp;
   logic [TW-1:0]             fill_ptr;
   logic [tpsf_pkg::CNT_W-1:0] outst;
   logic                      gfault;
   logic                      same_fault;
   logic                      is_fault;
   logic                      hum_ok;
   logic                      finish;
   logic                      take;
   tpsf_pkg::tpsf_fwd_type    cur;

   assign gfault     = (ctx >= tpsf_pkg::ID_W'(NUM_CTX));
   // until the first abort leaves, its page and context keep faulting
   assign same_fault = abort_valid_o && abort_o.ctx == ctx &&
                       abort_o.addr[tpsf_pkg::ADDR_W-1:tpsf_pkg::PAGE_LSB] == vpage;
   assign is_fault   = gfault | same_fault;
   assign finish     = (miss_st == tpsf_pkg::M_DONE) &&
                       (miss_fault ? ~abort_valid_o : ~fwd_valid_o);
   // reads always pass; writes pass a missed write only when its beats fit
   assign hum_ok     = (miss_st == tpsf_pkg::M_IDLE) || !req_i.write || !miss_txn.write ||
                       (WBUF_DEPTH != 0 && miss_txn.beats <= tpsf_pkg::BEAT_W'(WBUF_DEPTH));
   assign cur        = '{write: req_i.write, addr: {hit_pp, req_i.addr[tpsf_pkg::PAGE_LSB-1:0]},
                         ns: ns_sel, ctx: ctx};

   always_comb begin
      req_ready_o = 1'b0;
      if (lp_ack_cache_o && !maint_busy && !finish) begin
         if (is_fault) begin
            req_ready_o = ~abort_valid_o;
         end else if (hit) begin
            req_ready_o = ~fwd_valid_o & hum_ok;
         end else begin
            req_ready_o = (miss_st == tpsf_pkg::M_IDLE);
         end
      end
   end

   assign take      = req_valid_i & req_ready_o;
   assign fault_evt = (take && is_fault && (gfault ? ctrl[tpsf_pkg::CTRL_GFR]
                                                   : ctrl[tpsf_pkg::CTRL_CFR])) ||
                      (finish && miss_fault && ctrl[tpsf_pkg::CTRL_CFR]);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fault_addr <= 32'h0;
      end else if (fault_evt) begin
         fault_addr <= finish ? miss_txn.addr : req_i.addr;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         miss_st    <= tpsf_pkg::M_IDLE;
         miss_txn   <= '0;
         miss_ns    <= 1'b0;
         miss_fault <= 1'b0;
         miss_pp    <= '0;
      end else begin
         case (miss_st)
            tpsf_pkg::M_IDLE: begin
               if (take && !is_fault && !hit) begin
                  miss_st  <= tpsf_pkg::M_WALK;
                  miss_txn <= req_i;
                  miss_ns  <= ns_sel;
               end
            end
            tpsf_pkg::M_WALK: begin
               if (walk_done_i) begin
                  miss_st    <= tpsf_pkg::M_DONE;
                  miss_fault <= walk_fault_i;
                  miss_pp    <= walk_ppage_i;
               end
            end
            tpsf_pkg::M_DONE: begin
               if (finish) begin
                  miss_st <= tpsf_pkg::M_IDLE;
               end
            end
            default: miss_st <= tpsf_pkg::M_IDLE;
         endcase
      end
   end

   assign walk_req_o  = (miss_st == tpsf_pkg::M_WALK);
   assign walk_addr_o = miss_txn.addr;
   assign miss_ctx    = (miss_txn.write ? miss_txn.ctx_wr : miss_txn.ctx_rd) & CTX_MASK;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tlb_v    <= '0;
         fill_ptr <= '0;
         for (int i = 0; i < TLB_N; i++) begin
            tlb_ctx[i] <= '0;
            tlb_vp[i]  <= '0;
            tlb_pp[i]  <= '0;
         end
      end else if (maint_busy) begin
         tlb_v[TW'(maint_cnt - 1'b1)] <= 1'b0;
      end else if (walk_req_o && walk_done_i && !walk_fault_i) begin
         tlb_v[fill_ptr]   <= 1'b1;
         tlb_ctx[fill_ptr] <= miss_ctx;
         tlb_vp[fill_ptr]  <= miss_txn.addr[tpsf_pkg::ADDR_W-1:tpsf_pkg::PAGE_LSB];
         tlb_pp[fill_ptr]  <= walk_ppage_i;
         fill_ptr          <= (fill_ptr == TW'(TLB_N - 1)) ? '0 : fill_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fwd_valid_o <= 1'b0;
         fwd_o       <= '0;
      end else if (finish && !miss_fault) begin
         fwd_valid_o <= 1'b1;
         fwd_o       <= '{write: miss_txn.write,
                          addr: {miss_pp, miss_txn.addr[tpsf_pkg::PAGE_LSB-1:0]},
                          ns: miss_ns,
                          ctx: miss_ctx};
      end else if (take && hit && !is_fault) begin
         fwd_valid_o <= 1'b1;
         fwd_o       <= cur;
      end else if (fwd_ready_i) begin
         fwd_valid_o <= 1'b0;
      end
   end

   // faults end in an abort; a faulted miss waits in M_DONE until the abort slot is free
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         abort_valid_o <= 1'b0;
         abort_o       <= '0;
      end else if (finish && miss_fault) begin
         abort_valid_o <= 1'b1;
         abort_o       <= '{write: miss_txn.write, addr: miss_txn.addr, ns: miss_ns,
                            ctx: miss_ctx};
      end else if (take && is_fault) begin
         abort_valid_o <= 1'b1;
         abort_o       <= '{write: req_i.write, addr: req_i.addr, ns: ns_sel, ctx: ctx};
      end else if (abort_ready_i) begin
         abort_valid_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         outst <= '0;
      end else begin
         outst <= outst + tpsf_pkg::CNT_W'(fwd_valid_o & fwd_ready_i)
                        - tpsf_pkg::CNT_W'(fwd_done_i & (outst != '0));
      end
   end

   // ****************************************
   // low-power channels
   // ****************************************
   // each channel follows its own request; entry is never denied
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lp_ack_cache_o <= 1'b1;
      end else begin
         lp_ack_cache_o <= lp_req_cache_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lp_ack_walk_o <= 1'b1;
      end else begin
         lp_ack_walk_o <= lp_req_walk_i;
      end
   end

   assign lp_active_cache_o = (outst != '0) | req_valid_i | maint_busy |
                              (miss_st != tpsf_pkg::M_IDLE) | fwd_valid_o | abort_valid_o;
   // select is combinational here, so a divided port must sample it with its enable
   assign lp_active_walk_o  = (wb_cyc_i & wb_stb_i) | snoop_valid_i | walk_req_o;

   // ****************************************
   // checks
   // ****************************************
   a_cache_ack : assert property (@(posedge clk_i) disable iff (!arst_n_i)
      $fell(lp_req_cache_i) |=> !lp_ack_cache_o)
      else $error("cache sleep not acknowledged");
   a_walk_ack : assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !lp_req_walk_i ##1 !lp_req_walk_i |-> !lp_ack_walk_o)
      else $error("walk sleep not acknowledged");
   a_cache_idle : assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !lp_active_cache_o |-> outst == '0 && !req_valid_i && !maint_busy)
      else $error("cache idle while busy");
   a_walk_idle : assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wb_cyc_i && wb_stb_i) || snoop_valid_i || walk_req_o |-> lp_active_walk_o)
      else $error("walk idle while busy");
   a_side_ns : assert property (@(posedge clk_i) disable iff (!arst_n_i)
      take && hit && !is_fault && !ctrl[tpsf_pkg::CTRL_MODE] |=> fwd_valid_o &&
      fwd_o.ns == $past(req_i.write ? req_i.ns_wr : req_i.ns_rd))
      else $error("sideband security state lost");
   a_read_pass : assert property (@(posedge clk_i) disable iff (!arst_n_i)
      miss_st == tpsf_pkg::M_WALK && !req_i.write && hit && !is_fault && !fwd_valid_o &&
      lp_ack_cache_o && !maint_busy |-> req_ready_o)
      else $error("read hit blocked by miss");
   a_write_hold : assert property (@(posedge clk_i) disable iff (!arst_n_i)
      WBUF_DEPTH == 0 && miss_st != tpsf_pkg::M_IDLE && miss_txn.write &&
      req_i.write && !is_fault |-> !req_ready_o)
      else $error("write passed a missed write");
   a_fault_abort : assert property (@(posedge clk_i) disable iff (!arst_n_i)
      walk_req_o && walk_done_i && walk_fault_i |-> ##[1:64] abort_valid_o)
      else $error("walk fault not aborted");
   a_ctx_report : assert property (@(posedge clk_i) disable iff (!arst_n_i)
      finish && miss_fault && ctrl[tpsf_pkg::CTRL_CFR] |=> fault_st)
      else $error("context fault not reported");
   a_same_page : assert property (@(posedge clk_i) disable iff (!arst_n_i)
      req_valid_i && same_fault |-> is_fault && !req_ready_o)
      else $error("repeat fault passed");

endmodule

// File: rtl/tpsf_pkg.sv
// constants and carrier types of the translation unit power, security and fault block
// assumes a 100 MHz core clock and a 32-bit classic wishbone register port
package tpsf_pkg;

   // ****************************************
   // register map (byte offsets)
   // ****************************************
   localparam int          REG_AW      = 4;
   localparam logic [3:0]  REG_CTRL    = 4'h0;
   localparam logic [3:0]  REG_STATUS  = 4'h4;
   localparam logic [3:0]  REG_SECTAB  = 4'h8;
   localparam logic [3:0]  REG_FADDR   = 4'hC;

   // control fields
   localparam int CTRL_MODE  = 0;
   localparam int CTRL_GFR   = 1;
   localparam int CTRL_CFR   = 2;
   localparam int CTRL_MAINT = 3;
   localparam logic [2:0] CTRL_RST = 3'h0;

   // status fields
   localparam int ST_FAULT = 0;
   localparam int ST_MISS  = 1;
   localparam int ST_MAINT = 2;
   localparam int ST_ABORT = 3;

   // security table access word
   localparam int SEC_BIT   = 31;
   localparam int SEC_IDX_H = 14;

   // ****************************************
   // transaction layout
   // ****************************************
   localparam int ADDR_W   = 32;
   localparam int PAGE_LSB = 12;
   localparam int VP_W     = ADDR_W - PAGE_LSB;
   localparam int ID_W     = 15;
   localparam int BEAT_W   = 8;
   localparam int CNT_W    = 8;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [ID_W-1:0]   ctx_rd;
      logic [ID_W-1:0]   ctx_wr;
      logic              ns_rd;
      logic              ns_wr;
      logic [ID_W-1:0]   sec_idx;
      logic [BEAT_W-1:0] beats;
   } tpsf_txn_type;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic              ns;
      logic [ID_W-1:0]   ctx;
   } tpsf_fwd_type;

   typedef enum logic [1:0] {M_IDLE, M_WALK, M_DONE} tpsf_miss_type;

endpackage

// File: verif/tb_tpsf_core.sv
// self-checking bench of tpsf_core: register port, low power, security, hit under miss, faults
// assumes tpsf_far_model answers walks and downstream requests
`timescale 1ns/100ps
module tb_tpsf_core;
   typedef struct packed {logic ab; tpsf_pkg::tpsf_fwd_type f;} tpsf_note_type;
   localparam logic [19:0] PP = 20'h5A5A5;
   logic        clk_i = 0, arst_n_i = 0, cyc = 0, we = 0, rv = 0, snoop = 0, wf = 0;
   logic        lpc = 1, lpw = 1;
   logic [3:0]  adr = 4'h0;
   logic [31:0] dat = 32'h0, q, a, b;
   tpsf_pkg::tpsf_txn_type req = '0;
   tpsf_pkg::tpsf_fwd_type fwd_o, abort_o;
   tpsf_note_type exp_q[$], n;
   int          failures = 0, tests_run = 0, cycles = 0;
   logic [31:0] wb_dat_o, walk_addr_o;
   logic [19:0] pp_i;
   logic        wb_ack_o, lac, lav, law, laww, req_ready_o, fwd_valid_o, abort_valid_o;
   logic        walk_req_o, fwd_ready_i, fwd_done_i, abort_ready_i, walk_done_i;
   logic [3:0]  ix_t[3] = '{4'h3, 4'h9, 4'h8};
   logic        sec_t[3] = '{1'h1, 1'h0, 1'h1};

   tpsf_core #(.PROG_MASK(16'h00FF), .FIXED_SEC_MASK(16'h0100)) DUT (.clk_i(clk_i),
      .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .reg_clk_en_i(1'b1), .lp_req_cache_i(lpc), .lp_ack_cache_o(lac),
      .lp_active_cache_o(lav), .lp_req_walk_i(lpw), .lp_ack_walk_o(law),
      .lp_active_walk_o(laww), .req_valid_i(rv), .req_i(req), .req_ready_o(req_ready_o),
      .fwd_valid_o(fwd_valid_o), .fwd_o(fwd_o), .fwd_ready_i(fwd_ready_i),
      .fwd_done_i(fwd_done_i), .abort_valid_o(abort_valid_o), .abort_o(abort_o),
      .abort_ready_i(abort_ready_i), .walk_req_o(walk_req_o), .walk_addr_o(walk_addr_o),
      .walk_done_i(walk_done_i), .walk_fault_i(wf), .walk_ppage_i(pp_i),
      .snoop_valid_i(snoop));
   tpsf_far_model #(.PP_XOR(PP)) far (.clk_i(clk_i), .walk_req_i(walk_req_o),
      .walk_addr_i(walk_addr_o), .walk_done_o(walk_done_i), .walk_ppage_o(pp_i),
      .fwd_valid_i(fwd_valid_o), .fwd_ready_o(fwd_ready_i), .fwd_done_o(fwd_done_i),
      .abort_ready_o(abort_ready_i));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   task end_of_test;
      if (failures == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // ****************************************
   // bus and transaction drivers
   // ****************************************
   task wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1; we <= w; adr <= ad; dat <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 0;
   endtask

   // the unused sideband carries the opposite state so a wrong pick shows
   task send(input logic w, input logic [31:0] ad, input logic [14:0] c, input logic [3:0] ix,
             input logic [7:0] bt, input logic ns);
      @(posedge clk_i);
      // a free forward slot first, so the order of hits and misses stays predictable
      while (fwd_valid_o) @(posedge clk_i);
      rv <= 1;
      req <= '{w, ad, c, c, w ? ~ns : ns, w ? ns : ~ns, 15'(ix), bt};
      do @(posedge clk_i); while (req_ready_o !== 1'b1);
      rv <= 0;
   endtask

   task push(input logic ab, input logic w, input logic [31:0] ad, input logic ns);
      exp_q.push_back('{ab, '{w, {ad[31:12] ^ PP, ad[11:0]}, ns, 15'h0001}});
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (fwd_valid_o && fwd_ready_i) begin
         check(64'(fwd_o), 64'(exp_q.pop_front()));
      end
      if (abort_valid_o && abort_ready_i) begin
         n = exp_q.pop_front();
         check({n.ab, abort_o.write, abort_o.addr[11:0]},
               {1'b1, n.f.write, n.f.addr[11:0]});
      end
      if (cycles == 20000) begin
         failures++;
         end_of_test;
      end
   end

   initial begin
      void'($urandom(79264));
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1;
      @(posedge clk_i);
      lpc <= 0;
      snoop <= 1;
      repeat (2) @(posedge clk_i);
      check(lac, 0);
      check(law, 1);
      check(laww, 1);
      lpc <= 1;
      lpw <= 0;
      snoop <= 0;
      repeat (2) @(posedge clk_i);
      check(law, 0);
      check({laww, lav, lac}, 3'h1);
      lpw <= 1;
      a = 32'h0001_0000 | ($urandom & 32'hFFF);
      b = 32'h0002_0000 | ($urandom & 32'hFFF);
      send(0, a, 1, 0, 1, 1); push(0, 0, a, 1);
      send(1, a ^ 32'h8, 1, 0, 1, 0); push(0, 1, a ^ 32'h8, 0);
      send(0, b, 1, 0, 1, 1);
      send(0, a, 1, 0, 1, 0); push(0, 0, a, 0); push(0, 0, b, 1);
      @(posedge clk_i);
      check(lav, 1);
      for (int k = 0; k < 2; k++) begin
         b = (32'h0003_0000 + (k << 16)) | ($urandom & 32'hFFF);
         send(1, b, 1, 0, k ? 8'h02 : 8'h05, 1);
         if (k == 0) push(0, 1, b, 1);
         send(1, a, 1, 0, 1, 0); push(0, 1, a, 0);
         if (k == 1) push(0, 1, b, 1);
      end
      wb(1, tpsf_pkg::REG_CTRL, 32'h0000_0001);
      for (int k = 0; k < 3; k++) begin
         wb(1, tpsf_pkg::REG_SECTAB, 32'h8000_0000 | ix_t[k]);
         wb(0, tpsf_pkg::REG_SECTAB, 32'h0);
         check(64'(q), 64'({sec_t[k], 27'h0, ix_t[k]}));
         send(0, a, 1, ix_t[k], 1, $urandom % 2); push(0, 0, a, ~sec_t[k]);
      end
      wb(1, tpsf_pkg::REG_CTRL, 32'h0000_0003);
      push(1, 0, a, 0);
      send(0, a, 6, 3, 1, 0);
      repeat (20) @(posedge clk_i);
      wb(0, tpsf_pkg::REG_STATUS, 32'h0);
      check(64'(q), 64'h1);
      // context fault: a faulting walk, then a same-page access while its abort stands
      wb(1, tpsf_pkg::REG_STATUS, 32'h0000_0001);
      wb(1, tpsf_pkg::REG_CTRL, 32'h0000_0005);
      wf <= 1;
      b = 32'h0007_0000 | ($urandom & 32'hFFF);
      push(1, 0, b, 0); push(1, 0, b, 0);
      send(0, b, 1, 0, 1, 0);
      send(0, b, 1, 0, 1, 0);
      repeat (20) @(posedge clk_i);
      wf <= 0;
      wb(0, tpsf_pkg::REG_STATUS, 32'h0);
      check(64'(q), 64'h1);
      wb(0, tpsf_pkg::REG_FADDR, 32'h0);
      check(64'(q), 64'(b));
      wb(1, tpsf_pkg::REG_CTRL, 32'h0000_0008);
      wb(0, tpsf_pkg::REG_STATUS, 32'h0);
      check(64'(q), 64'h5);
      wb(0, 4'h2, 32'h0);
      check(64'(q), 64'h0);
      check(exp_q.size(), 0);
      end_of_test;
   end
endmodule

// File: verif/tpsf_far_model.sv
// far-side model: table walk engine and downstream slave with random stalls
// assumes the block samples every handshake on the rising clock edge
`timescale 1ns/100ps
module tpsf_far_model #(
   parameter int          WALK_DLY = 6,
   parameter logic [19:0] PP_XOR   = 20'h5A5A5
) (
   // clock
   input  wire logic        clk_i,
   // walk side
   input  wire logic        walk_req_i,
   input  wire logic [31:0] walk_addr_i,
   output      logic        walk_done_o,
   output      logic [19:0] walk_ppage_o,
   // downstream side
   input  wire logic        fwd_valid_i,
   output      logic        fwd_ready_o,
   output      logic        fwd_done_o,
   output      logic        abort_ready_o
);
   int cnt = 0;

   initial begin
      {walk_done_o, fwd_ready_o, fwd_done_o, abort_ready_o} = 4'h0;
      walk_ppage_o = 20'h00000;
   end

   // ****************************************
   // ready stalls are random so both prompt and slow answers occur; walks always take the fixed WALK_DLY delay
   // ****************************************
   always @(posedge clk_i) begin
      fwd_ready_o   <= $urandom % 2;
      abort_ready_o <= $urandom % 2;
      fwd_done_o    <= fwd_valid_i && fwd_ready_o;
      walk_done_o   <= 1'b0;
      // page lines toggle outside the done pulse so a stale value never looks valid
      walk_ppage_o  <= ~walk_ppage_o;
      cnt           <= (walk_req_i && !walk_done_o) ? cnt + 1 : 0;
      if (cnt == WALK_DLY) begin
         walk_done_o  <= 1'b1;
         walk_ppage_o <= walk_addr_i[31:12] ^ PP_XOR;
      end
   end
endmodule
